// ---- power_down_mode_control.sv ----
// Purpose: Sleep, software standby, hardware standby, multi-clock and RAM stop control.
// Assumes: All pins are synchronous to clk_i; CPU pulses sleep_exec_i for SLEEP.
// Notes:   Slower clocks are one-cycle enables from a single divider counter.
//
// Summary of operation
// R1 - RAM stop bits stop matching RAM block
// R2 - Software never stops RAM mid-access
// R3 - RAM register high byte ones, bits 7-3 zero
// R4 - Nonzero clock select enters multi-clock mode
// R5 - CPU, peripheral, bus clocks follow own fields
// R6 - Peripheral and bus clocks clamped to system
// R7 - All selects zero returns to normal mode
// R8 - SLEEP with select clear enters sleep
// R9 - SLEEP with select set enters standby
// R10 - Reset pin or watchdog cancels multi-clock
// R11 - Standby pin low enters hardware standby
// R12 - Sleep halts CPU, peripherals keep running
// R13 - Accepted interrupt ends sleep with exception
// R14 - Reset pin low ends sleep via reset
// R15 - Watchdog overflow reset ends sleep
// R16 - Standby stops CPU, peripherals, oscillator
// R17 - Output hold bit chooses bus float
// R18 - Watchdog mode refuses software standby
// R19 - NMI or enabled IRQ wakes after settling
// R20 - Masked or transfer-source IRQ never wakes
// R21 - Per-pin enable gates IRQ standby wake
// R22 - Reset pin in standby restarts oscillator
// R23 - Module stop acts at bus cycle end
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pdm_defines.svh"

module power_down_mode_control #(
    parameter int SETTLE_SHIFT = 0  // Right shift of settling counts, for short simulations.
) (
    input  wire logic                clk_i,               // System clock, 100 MHz.
    input  wire logic                rst_i,               // Synchronous reset, active high.
    // Wishbone slave.
    input  wire logic                cyc_i,               // Bus cycle.
    input  wire logic                stb_i,               // Strobe.
    input  wire logic                we_i,                // Write enable.
    input  wire logic [7:0]          adr_i,               // Byte address.
    input  wire logic [3:0]          sel_i,               // Byte lane selects.
    input  wire logic [31:0]         dat_i,               // Write data.
    output logic      [31:0]         dat_o,               // Read data.
    output logic                     ack_o,               // Acknowledge.
    // CPU and pins.
    input  wire logic                sleep_exec_i,        // SLEEP executed, one-cycle pulse.
    input  wire logic                int_accept_i,        // Enabled, unmasked interrupt or NMI.
    input  wire logic                reset_pin_n_i,       // External reset pin, active low.
    input  wire logic                wdt_reset_i,         // Watchdog overflow reset.
    input  wire logic                watchdog_mode_i,     // Watchdog runs in watchdog mode.
    input  wire logic                hw_standby_pin_n_i,  // Hardware standby pin, active low.
    input  wire pdm_pkg::wake_src_t  wake_i,              // NMI and IRQ request levels.
    input  wire logic [11:0]         irq_cpu_masked_i,    // IRQ masked by the CPU.
    input  wire logic [11:0]         irq_dtc_source_i,    // IRQ assigned to the transfer controller.
    // Controls to the chip.
    output logic      [2:0]          ram_stop_o,          // RAM block stop: 2, 1, 0.
    output logic                     cpu_clk_en_o,        // CPU and bus master clock enable.
    output logic                     periph_clk_en_o,     // Peripheral clock enable.
    output logic                     bus_clk_en_o,        // External bus clock enable.
    output logic                     multi_clock_o,       // Multi-clock mode active.
    output logic                     osc_run_o,           // Oscillator running.
    output logic                     bus_float_o,         // Address and bus control float.
    output logic                     serial_reset_o,      // Serial interface held in reset.
    output logic                     chip_reset_o,        // Chip-wide reset.
    output logic                     wake_exception_o,    // Start interrupt exception, pulse.
    output pdm_pkg::pdm_state_t      state_o              // Current mode.
);

    // ************************************************************
    // Functions.
    // ************************************************************

    // Tick of a power-of-two divider taken from the shared counter.
    function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] sel);
        logic [6:0] mask;
        mask = 7'((8'h01 << sel) - 8'h01);
        return (cnt & mask) == 7'h00;
    endfunction : div_tick

    // The slower of two selects, so no clock exceeds the system clock.
    function automatic logic [2:0] clamp_sel(input logic [2:0] sys, input logic [2:0] req);
        return (req < sys) ? sys : req;
    endfunction : clamp_sel

    // Settling count for a settling-time code; reserved codes take the longest.
    function automatic logic [19:0] settle_count(input logic [4:0] sts);
        logic [19:0] c;
        c = `PDM_SETTLE_512K;
        unique case (sts)
            5'h05:   c = `PDM_SETTLE_64;
            5'h06:   c = `PDM_SETTLE_512;
            5'h07:   c = `PDM_SETTLE_1K;
            5'h08:   c = `PDM_SETTLE_2K;
            5'h09:   c = `PDM_SETTLE_4K;
            5'h0a:   c = `PDM_SETTLE_16K;
            5'h0b:   c = `PDM_SETTLE_32K;
            5'h0c:   c = `PDM_SETTLE_64K;
            5'h0d:   c = `PDM_SETTLE_128K;
            5'h0e:   c = `PDM_SETTLE_256K;
            default: c = `PDM_SETTLE_512K;
        endcase
        c = c >> SETTLE_SHIFT;
        return (c == 20'h00000) ? 20'h00001 : c;
    endfunction : settle_count

    // ************************************************************
    // Storage.
    // ************************************************************
    logic [2:0]          ram_stop_q;    // RAM stop bits.
    pdm_pkg::clk_sel_t   clk_sel_q;     // Clock select fields.
    logic                standby_select_bit_q;        // Standby select.
    logic                ope_q;         // Output hold in standby.
    logic [4:0]          sts_q;         // Settling time code.
    logic [11:0]         wake_en_q;     // Per-pin standby wake enable.
    logic                ack_q;         // Wishbone acknowledge.
    logic [31:0]         rdata_q;       // Registered read data.
    logic [6:0]          div_q;         // Shared divider counter.
    logic [19:0]         settle_q;      // Settling countdown.
    logic [19:0]         settle_d;      // Next settling countdown.
    logic                wake_q;        // Wake exception pulse.
    logic                wake_d;        // Next wake pulse.
    pdm_pkg::pdm_state_t state_q;       // Current mode.
    pdm_pkg::pdm_state_t state_d;       // Next mode.

    // ************************************************************
    // Decoding.
    // ************************************************************
    wire logic        chip_rst   = rst_i | ~reset_pin_n_i | wdt_reset_i;  // R10
    wire logic        bus_req    = cyc_i & stb_i & ~ack_q;
    wire logic        wr_en      = bus_req & we_i & sel_i[0];
    wire logic        wr_en_hi   = bus_req & we_i & sel_i[1];
    wire logic        hit_ram    = adr_i == `PDM_OFS_RAM_STOP;
    wire logic        hit_clk    = adr_i == `PDM_OFS_CLK_DIV;
    wire logic        hit_sby    = adr_i == `PDM_OFS_STANDBY;
    wire logic        hit_wake   = adr_i == `PDM_OFS_WAKE_EN;
    wire logic        hit_stat   = adr_i == `PDM_OFS_STATUS;
    wire logic        multi_clk  = clk_sel_q != 9'h000;  // R4 R7
    wire logic [2:0]  isel       = clk_sel_q.system_clock_select;
    wire logic [2:0]  psel_eff   = clamp_sel(isel, clk_sel_q.peripheral_clock_select);  // R6
    wire logic [2:0]  bsel_eff   = clamp_sel(isel, clk_sel_q.external_bus_clock_select);  // R6
    wire logic [11:0] irq_wake   = wake_i.irq & wake_en_q & ~irq_cpu_masked_i
                                   & ~irq_dtc_source_i;  // R20 R21
    wire logic        std_wake   = wake_i.nmi | (irq_wake != 12'h000);  // R19
    wire logic        in_hw_standby_pin_n    = (state_q == pdm_pkg::ST_SW_STANDBY)
                                   | (state_q == pdm_pkg::ST_SETTLE);
    wire logic [15:0] ram_rd     = `PDM_RAM_FIXED_ONES | {13'h0000, ram_stop_q};  // R3
    wire logic [15:0] clk_rd     = {5'h00, clk_sel_q.external_bus_clock_select, 1'b0,
                                    clk_sel_q.peripheral_clock_select, 1'b0, isel};
    wire logic [15:0] sby_rd     = {standby_select_bit_q, ope_q, 1'b0, sts_q, 8'h00};
    wire logic [15:0] stat_rd    = {11'h000, multi_clk, 1'b0, state_q};

    // Read multiplexer; unmapped addresses read as zero.
    wire logic [15:0] rd_mux = hit_ram  ? ram_rd :
                               hit_clk  ? clk_rd :
                               hit_sby  ? sby_rd :
                               hit_wake ? {4'h0, wake_en_q} :
                               hit_stat ? stat_rd : 16'h0000;

    // ************************************************************
    // Bus slave.
    // ************************************************************

    // One wait state: ack rises the cycle after the request and drops after one cycle.
    always_ff @(posedge clk_i)
    begin
        if (chip_rst)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q   <= bus_req;
            rdata_q <= {16'h0000, rd_mux};
        end
    end

    // Register writes land in the cycle the bus cycle ends, so modes change there.
    always_ff @(posedge clk_i)
    begin
        if (chip_rst)
        begin
            ram_stop_q <= `PDM_RAM_STOP_RST;  // R10
            clk_sel_q  <= '0;  // R10
            standby_select_bit_q     <= 1'b0;
            ope_q      <= 1'b0;
            sts_q      <= `PDM_STS_RST;
            wake_en_q  <= `PDM_WAKE_EN_RST;
        end
        else
        begin
            // Only the three stop bits are stored; the rest are fixed.
            if (wr_en && hit_ram)
            begin
                ram_stop_q <= dat_i[2:0];  // R1 R3 R23
            end
            // A nonzero write enters multi-clock mode, all zero leaves it.
            if (wr_en && hit_clk)
            begin
                clk_sel_q.system_clock_select     <= dat_i[`PDM_ISEL_LSB +: 3];  // R4 R7
                clk_sel_q.peripheral_clock_select <= dat_i[`PDM_PSEL_LSB +: 3];
            end
            if (wr_en_hi && hit_clk)
            begin
                clk_sel_q.external_bus_clock_select <= dat_i[`PDM_BSEL_LSB +: 3];
            end
            // Standby controls sit in the upper byte.
            if (wr_en_hi && hit_sby)
            begin
                standby_select_bit_q <= dat_i[`PDM_STANDBY_SELECT_BIT_BIT];
                ope_q  <= dat_i[`PDM_OPE_BIT];
                sts_q  <= dat_i[`PDM_STS_LSB +: 5];
            end
            if (wr_en && hit_wake)
            begin
                wake_en_q[7:0] <= dat_i[7:0];
            end
            if (wr_en_hi && hit_wake)
            begin
                wake_en_q[11:8] <= dat_i[11:8];
            end
        end
    end

    // ************************************************************
    // Clock enables.
    // ************************************************************

    // Free-running divider; stopped while the oscillator is stopped.
    always_ff @(posedge clk_i)
    begin
        if (chip_rst)
        begin
            div_q <= 7'h00;
        end
        else if (osc_run_o)
        begin
            div_q <= div_q + 7'h01;
        end
    end

    // CPU runs only in run mode; peripherals also run in sleep.
    assign cpu_clk_en_o    = (state_q == pdm_pkg::ST_RUN) & div_tick(div_q, isel);  // R5 R12
    assign periph_clk_en_o = ((state_q == pdm_pkg::ST_RUN) | (state_q == pdm_pkg::ST_SLEEP))
                             & div_tick(div_q, psel_eff);  // R5 R12 R16
    assign bus_clk_en_o    = ((state_q == pdm_pkg::ST_RUN) | (state_q == pdm_pkg::ST_SLEEP))
                             & div_tick(div_q, bsel_eff);  // R5 R16

    // ************************************************************
    // Mode sequencer.
    // ************************************************************

    // Next mode from the current mode, SLEEP and wake events.
    always_comb
    begin
        state_d  = state_q;
        settle_d = settle_q;
        wake_d   = 1'b0;
        unique case (state_q)
            pdm_pkg::ST_RUN:
            begin
                // Standby is refused while the watchdog guards the system.
                if (sleep_exec_i && !standby_select_bit_q)
                begin
                    state_d = pdm_pkg::ST_SLEEP;  // R8
                end
                else if (sleep_exec_i && standby_select_bit_q && !watchdog_mode_i)
                begin
                    state_d = pdm_pkg::ST_SW_STANDBY;  // R9 R18
                end
            end
            pdm_pkg::ST_SLEEP:
            begin
                // The select fields were never touched, so multi-clock resumes.
                if (int_accept_i)
                begin
                    state_d = pdm_pkg::ST_RUN;  // R8 R13
                    wake_d  = 1'b1;
                end
            end
            pdm_pkg::ST_SW_STANDBY:
            begin
                if (std_wake)
                begin
                    state_d  = pdm_pkg::ST_SETTLE;  // R19
                    settle_d = settle_count(sts_q);
                end
            end
            pdm_pkg::ST_SETTLE:
            begin
                // Oscillator runs but clocks are held off until it settles.
                if (settle_q <= 20'h00001)
                begin
                    state_d = pdm_pkg::ST_RUN;  // R9 R19
                    wake_d  = 1'b1;
                end
                else
                begin
                    settle_d = settle_q - 20'h00001;
                end
            end
            pdm_pkg::ST_HW_STANDBY:
            begin
                // Leaving passes through reset, held by the reset pin outside.
                state_d = pdm_pkg::ST_RUN;
            end
            default:
            begin
                state_d = pdm_pkg::ST_RUN;
            end
        endcase
    end

    // Reset and the standby pin override every mode.
    always_ff @(posedge clk_i)
    begin
        if (!hw_standby_pin_n_i)
        begin
            state_q  <= pdm_pkg::ST_HW_STANDBY;  // R11
            settle_q <= 20'h00000;
            wake_q   <= 1'b0;
        end
        else if (chip_rst)
        begin
            state_q  <= pdm_pkg::ST_RUN;  // R14 R15 R22
            settle_q <= 20'h00000;
            wake_q   <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            settle_q <= settle_d;
            wake_q   <= wake_d;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign state_o          = state_q;
    assign ram_stop_o       = ram_stop_q;  // R1
    assign multi_clock_o    = multi_clk;
    assign chip_reset_o     = chip_rst | (state_q == pdm_pkg::ST_HW_STANDBY);
    assign wake_exception_o = wake_q;  // R13 R19
    // A reset pin low restarts the oscillator at once, even from standby.
    assign osc_run_o        = chip_rst | ((state_q != pdm_pkg::ST_SW_STANDBY)
                              & (state_q != pdm_pkg::ST_HW_STANDBY));  // R16 R22
    assign bus_float_o      = (in_hw_standby_pin_n & ~ope_q) | (state_q == pdm_pkg::ST_HW_STANDBY);  // R17
    assign serial_reset_o   = in_hw_standby_pin_n;  // R16
    assign dat_o            = rdata_q;
    assign ack_o            = ack_q;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_bus_ack_one: assert property (bus_req |=> ack_o ##1 !ack_o)  // R23
        else $error("ack not a single cycle after request");
    chk_ram_fixed_bits: assert property (bus_req && hit_ram && !we_i
        |=> dat_o[15:3] == 13'h1fe0)  // R3
        else $error("RAM stop register fixed bits wrong");
    chk_ram_stop_write: assert property (wr_en && hit_ram && !chip_rst && hw_standby_pin_n_i
        |=> ram_stop_o == $past(dat_i[2:0]))  // R1
        else $error("RAM stop write not applied");
    chk_clamp_periph: assert property (multi_clk |-> psel_eff >= isel && bsel_eff >= isel)  // R6
        else $error("peripheral clock faster than system clock");
    chk_reset_cancel: assert property (!reset_pin_n_i || wdt_reset_i |=> !multi_clock_o)  // R10
        else $error("reset did not cancel multi-clock");
    chk_sleep_exit: assert property (state_q == pdm_pkg::ST_SLEEP && int_accept_i && !chip_rst
        && hw_standby_pin_n_i |=> state_q == pdm_pkg::ST_RUN && wake_exception_o)  // R13
        else $error("interrupt did not end sleep");
    chk_wdt_refuse: assert property (state_q == pdm_pkg::ST_RUN && sleep_exec_i && standby_select_bit_q
        && watchdog_mode_i |=> state_q != pdm_pkg::ST_SW_STANDBY)  // R18
        else $error("standby entered in watchdog mode");
    chk_no_false_wake: assert property (state_q == pdm_pkg::ST_SW_STANDBY && !std_wake
        && !chip_rst && hw_standby_pin_n_i |=> state_q == pdm_pkg::ST_SW_STANDBY)  // R20 R21
        else $error("standby left without a wake source");
    chk_settle_clocks: assert property (state_q == pdm_pkg::ST_SETTLE
        |-> osc_run_o && !cpu_clk_en_o && !periph_clk_en_o)  // R19
        else $error("clocks supplied before settling");
    chk_hw_standby: assert property (!hw_standby_pin_n_i |=> state_q == pdm_pkg::ST_HW_STANDBY
        && chip_reset_o && bus_float_o)  // R11
        else $error("standby pin ignored");
    chk_sleep_periph: assert property (state_q == pdm_pkg::ST_SLEEP
        |-> !cpu_clk_en_o && (div_tick(div_q, psel_eff) == periph_clk_en_o))  // R12
        else $error("sleep clocks wrong");

    cov_sleep_wake: cover property (state_q == pdm_pkg::ST_SLEEP ##1 wake_exception_o);
    cov_standby_wake: cover property (state_q == pdm_pkg::ST_SETTLE ##1 state_q == pdm_pkg::ST_RUN);
    cov_multi_clock: cover property (multi_clk && psel_eff != isel);
    cov_reset_standby: cover property (state_q == pdm_pkg::ST_SW_STANDBY && !reset_pin_n_i);

endmodule : power_down_mode_control
`default_nettype wire

// ---- pdm_defines.svh ----
// Purpose: Offsets, field positions, reset values and counts of the power-down control.
// Assumes: A 32-bit classic Wishbone slave decodes byte addresses on word boundaries.
// Notes:   Definitions only; included by bare name.
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define PDM_OFS_RAM_STOP   8'h00
`define PDM_OFS_CLK_DIV    8'h04
`define PDM_OFS_STANDBY    8'h08
`define PDM_OFS_WAKE_EN    8'h0c
`define PDM_OFS_STATUS     8'h10

// ************************************************************
// Field layout and fixed bits.
// ************************************************************
`define PDM_RAM_FIXED_ONES 16'hff00
`define PDM_RAM_STOP_MASK  16'h0007
`define PDM_RAM_STOP_RST   3'h0
`define PDM_ISEL_LSB       0
`define PDM_PSEL_LSB       4
`define PDM_BSEL_LSB       8
`define PDM_STS_LSB        8
`define PDM_OPE_BIT        14
`define PDM_STANDBY_SELECT_BIT_BIT       15
`define PDM_STS_RST        5'h0f
`define PDM_WAKE_EN_RST    12'h000

// ************************************************************
// Oscillation settling counts in clock cycles.
// ************************************************************
`define PDM_SETTLE_64      20'h00040
`define PDM_SETTLE_512     20'h00200
`define PDM_SETTLE_1K      20'h00400
`define PDM_SETTLE_2K      20'h00800
`define PDM_SETTLE_4K      20'h01000
`define PDM_SETTLE_16K     20'h04000
`define PDM_SETTLE_32K     20'h08000
`define PDM_SETTLE_64K     20'h10000
`define PDM_SETTLE_128K    20'h20000
`define PDM_SETTLE_256K    20'h40000
`define PDM_SETTLE_512K    20'h80000

`endif

// ---- pdm_pkg.sv ----
// Purpose: Types shared by the power-down control.
// Assumes: Offsets and counts live in pdm_defines.svh.
// Notes:   Nothing here is imported; users write pdm_pkg::name.
package pdm_pkg;

    // Operating mode of the chip as seen by the power-down control.
    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP,
        ST_SW_STANDBY,
        ST_SETTLE,
        ST_HW_STANDBY
    } pdm_state_t;

    // Three clock select fields; larger values divide further.
    typedef struct packed {
        logic [2:0] external_bus_clock_select;
        logic [2:0] peripheral_clock_select;
        logic [2:0] system_clock_select;
    } clk_sel_t;

    // External wake sources sampled in software standby.
    typedef struct packed {
        logic        nmi;
        logic [11:0] irq;
    } wake_src_t;

endpackage : pdm_pkg

// ---- cpu_pin_model.sv ----
// Purpose: CPU and reset pin stand-in for the power-down control.
// Assumes: The bench raises each request for one cycle.
// Notes:   The reset pin stays low past the longest settling span used.
`timescale 1ns/10ps
`default_nettype none
module cpu_pin_model (
    input  wire logic clk_i,         // System clock.
    input  wire logic sleep_req_i,   // Bench asks for one SLEEP.
    input  wire logic reset_req_i,   // Bench asks for a reset pulse.
    output logic      sleep_exec_o,  // SLEEP executed pulse.
    output logic      reset_pin_n_o  // Reset pin, active low.
);
    logic [7:0] hold_q;  // Cycles the reset pin still stays low.
    initial
    begin
        sleep_exec_o  = 1'b0;
        reset_pin_n_o = 1'b1;
        hold_q        = 8'h00;
    end
    // Pin held low well beyond the settling time before release.
    always @(posedge clk_i)
    begin
        sleep_exec_o  <= sleep_req_i;
        hold_q        <= reset_req_i ? 8'hc8 : hold_q - {7'h0, hold_q != 8'h00};
        reset_pin_n_o <= !(reset_req_i || hold_q > 8'h01);
    end
endmodule : cpu_pin_model
`default_nettype wire

// ---- test_power_down_mode_control.sv ----
// Purpose: Self-checking bench of the power-down control.
// Assumes: Wishbone answers within a few cycles; SETTLE_SHIFT shortens settling.
// Notes: Software never touches RAM while changing stop bits.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_power_down_mode_control;
    logic               clk_i, rst_i, cyc_q, stb_q, we_q, req_s, req_r, acc_q, wdm_q, hwsb_q;
    logic [11:0]        msk_q;
    logic [7:0]         adr_q, cnt;
    logic [31:0]        dat_q, rd_q, dat_o;
    logic               ack_o, slp, rpn, cpu_en, per_en, mc, osc, wk;
    pdm_pkg::wake_src_t wake_q;
    pdm_pkg::pdm_state_t st;
    int                 err_count, tests_run;
    initial
    begin
        {clk_i, rst_i, cyc_q, stb_q, we_q, req_s, req_r, acc_q, wdm_q, hwsb_q} = 10'h101;
        {adr_q, dat_q, wake_q, msk_q, err_count, tests_run} = '0;
        forever #5 clk_i = ~clk_i;
    end
    cpu_pin_model u_cpu (.clk_i(clk_i), .sleep_req_i(req_s), .reset_req_i(req_r),
        .sleep_exec_o(slp), .reset_pin_n_o(rpn));
    power_down_mode_control #(.SETTLE_SHIFT(12)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_q), .stb_i(stb_q), .we_i(we_q), .adr_i(adr_q), .sel_i(4'h3),
        .dat_i(dat_q), .dat_o(dat_o), .ack_o(ack_o), .sleep_exec_i(slp),
        .int_accept_i(acc_q), .reset_pin_n_i(rpn), .wdt_reset_i(1'b0),
        .watchdog_mode_i(wdm_q), .hw_standby_pin_n_i(hwsb_q), .wake_i(wake_q),
        .irq_cpu_masked_i(msk_q), .irq_dtc_source_i(12'h000), .ram_stop_o(),
        .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .bus_clk_en_o(),
        .multi_clock_o(mc), .osc_run_o(osc), .bus_float_o(), .serial_reset_o(),
        .chip_reset_o(), .wake_exception_o(wk), .state_o(st));
    // Prints the counts and the verdict, then stops.
    task automatic finish_test;
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test
    // One classic Wishbone cycle; held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        {cyc_q, stb_q, we_q, adr_q, dat_q} <= {2'h3, w, a, d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1)
        begin
            err_count++;
            finish_test();
        end
        rd_q = dat_o;
        {cyc_q, stb_q} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    // Waits a bounded time for a mode, then compares it.
    task automatic wait_st(input pdm_pkg::pdm_state_t s);
        int n;
        for (n = 0; st !== s && n < 300; n++)
            @(posedge clk_i);
        `CHK(st, s)
        if (n >= 300)
            finish_test();
    endtask : wait_st
    // Asks the CPU stand-in for one SLEEP.
    task automatic sleep_cmd;
        req_s <= 1'b1;
        @(posedge clk_i);
        req_s <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : sleep_cmd
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        `CHK(rd_q, 32'h0000ff00)
        wb(1'b1, 8'h00, 32'h0000ffff);
        wb(1'b0, 8'h00, 32'h0);
        `CHK({rd_q, u_dut.ram_stop_o}, {32'h0000ff07, 3'h7})
        wb(1'b0, 8'h20, 32'h0);
        `CHK(rd_q, 32'h0)
        $display("registers done");
        wb(1'b1, 8'h04, 32'h00000013);
        `CHK(mc, 1'b1)
        cnt = 8'h00;
        repeat (32)
        begin
            @(posedge clk_i);
            cnt += {7'h0, per_en} + {7'h0, cpu_en};
        end
        `CHK(cnt, 8'h08)
        $display("clocks done");
        wb(1'b1, 8'h08, 32'h00000f00);
        sleep_cmd();
        wait_st(pdm_pkg::ST_SLEEP);
        `CHK({cpu_en, mc}, 2'h1)
        acc_q <= 1'b1;
        wait_st(pdm_pkg::ST_RUN);
        `CHK(wk, 1'b1)
        acc_q <= 1'b0;
        `CHK(mc, 1'b1)
        wdm_q <= 1'b1;
        wb(1'b1, 8'h08, 32'h00008f00);
        sleep_cmd();
        `CHK(st, pdm_pkg::ST_RUN)
        wdm_q <= 1'b0;
        wake_q.irq[0] <= 1'b1;
        sleep_cmd();
        wait_st(pdm_pkg::ST_SW_STANDBY);
        `CHK({osc, st}, {1'b0, pdm_pkg::ST_SW_STANDBY})
        wake_q.nmi <= 1'b1;
        wait_st(pdm_pkg::ST_SETTLE);
        wake_q <= '0;
        wait_st(pdm_pkg::ST_RUN);
        `CHK(mc, 1'b1)
        msk_q <= 12'h001;
        wake_q.irq[0] <= 1'b1;
        wb(1'b1, 8'h0c, 32'h00000001);
        sleep_cmd();
        `CHK(st, pdm_pkg::ST_SW_STANDBY)
        msk_q <= 12'h000;
        wait_st(pdm_pkg::ST_SETTLE);
        wake_q <= '0;
        wait_st(pdm_pkg::ST_RUN);
        `CHK(wk, 1'b1)
        $display("modes done");
        req_r <= 1'b1;
        @(posedge clk_i);
        req_r <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(mc, 1'b0)
        repeat (220) @(posedge clk_i);
        wb(1'b0, 8'h04, 32'h0);
        `CHK(rd_q, 32'h0)
        hwsb_q <= 1'b0;
        wait_st(pdm_pkg::ST_HW_STANDBY);
        hwsb_q <= 1'b1;
        wait_st(pdm_pkg::ST_RUN);
        $display("reset done");
        finish_test();
    end
endmodule : test_power_down_mode_control
`default_nettype wire
